// ==== rtl/flsh_consts.vh ====
/*
  Shared constants of the flash status-polling controller: register offsets,
  field positions, command codes and bus-cycle timing.
  Assumes inclusion by both design modules and the bench; definitions only.
*/
`ifndef FLSH_CONSTS_VH
`define FLSH_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define FLSH_REG_CTRL 5'h00
`define FLSH_REG_ADDR 5'h04
`define FLSH_REG_DATA 5'h08
`define FLSH_REG_STAT 5'h0C

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define FLSH_CTRL_START 0
`define FLSH_CTRL_OP_LO 1
`define FLSH_CTRL_OP_HI 2
`define FLSH_CTRL_USE_T2 3
`define FLSH_CTRL_ABORT 4

// operation codes
`define FLSH_OP_READ 2'h0
`define FLSH_OP_WRITE 2'h1
`define FLSH_OP_DPOLL 2'h2
`define FLSH_OP_TOGGLE 2'h3

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define FLSH_STAT_BUSY 0
`define FLSH_STAT_DONE 1
`define FLSH_STAT_FAIL 2
`define FLSH_STAT_EWC 3
`define FLSH_STAT_RD_LO 8
`define FLSH_STAT_RD_HI 15

// ----------------------------------------------------------------------
// status bit positions on the flash data pins
// ----------------------------------------------------------------------
`define FLSH_POLARITY_POLL_BIT 7
`define FLSH_BUSY_TOGGLE_BIT 6
`define FLSH_TIMEOUT_FAILURE_BIT 5
`define FLSH_ERASE_WINDOW_CLOSED_BIT 3
`define FLSH_SECTOR_ERASE_TOGGLE_BIT 2

// reset command byte
`define FLSH_CMD_RESET 8'hF0

// ----------------------------------------------------------------------
// bus-cycle timing
// ----------------------------------------------------------------------
`define FLSH_CLK_NS 25
`define FLSH_T_ACC_NS 70
`define FLSH_T_WP_NS 35
`define FLSH_RD_CYC ((`FLSH_T_ACC_NS + `FLSH_CLK_NS - 1) / `FLSH_CLK_NS)
`define FLSH_WR_CYC ((`FLSH_T_WP_NS + `FLSH_CLK_NS - 1) / `FLSH_CLK_NS)

`endif

// ==== rtl/flsh_cyc.v ====
/*
  One flash bus cycle, read or write, on chip-select, output strobe and
  write strobe.
  Assumes the flash answers within the access time held in the header and
  that data pins are sampled synchronously to clk.
*/
`timescale 1ns/1ps
`include "flsh_consts.vh"

module flsh_cyc #(
  parameter AW = 19,
  parameter RD_CYC = `FLSH_RD_CYC,
  parameter WR_CYC = `FLSH_WR_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // request side
  input wire req,
  input wire wr,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg done,
  output reg [7:0] rdata,
  // flash pins
  output reg [AW-1:0] fl_addr,
  input wire [7:0] fl_dq_in,
  output reg [7:0] fl_dq_out,
  output reg fl_dq_oe,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n
);

  localparam S_IDLE = 2'h0;
  localparam S_STROBE = 2'h1;
  localparam S_RECOV = 2'h2;

  reg [1:0] state_reg;
  reg [3:0] cnt_reg;
  reg wr_reg;

  // --------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------
  // at least two idle cycles between strobes so successive reads are distinct cycles
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      fl_addr <= {AW{1'b0}};
      fl_dq_out <= 8'h00;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req) begin
            wr_reg <= wr;
            fl_addr <= addr;
            fl_dq_out <= wdata;
            fl_dq_oe <= wr;
            fl_ce_n <= 1'b0;
            fl_oe_n <= wr;
            fl_we_n <= ~wr;
            cnt_reg <= wr ? WR_CYC[3:0] : RD_CYC[3:0];
            state_reg <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (cnt_reg == 4'h1) begin
            if (!wr_reg) begin
              rdata <= fl_dq_in;
            end
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            state_reg <= S_RECOV;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        S_RECOV: begin
          fl_dq_oe <= 1'b0;
          done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== rtl/flsh_poll.v ====
/*
  Host-side controller for a byte-wide flash: single read and write cycles
  ordered by software, plus hardware polarity polling and toggle checking
  of embedded program and erase progress, with automatic reset on failure.
  Assumes an AXI4-Lite master on the register side and the flash pins
  wired directly, with the testbench resolving the data bus from fl_dq_oe.
*/
// Implementation choices: the register offsets and register access over AXI4-Lite.
// Overview of operation
// - poll reads use the programmed address
// - erase poll address inside chosen sector
// - trust data only after poll flips
// - two reads, unchanged toggle means finished
// - toggling with timeout: recheck, then reset
// - resumed polling restarts the double read
// - after timeout, issue reset command
// - reset is one F0 write anywhere
`timescale 1ns/1ps
`include "flsh_consts.vh"

module flsh_poll #(
  parameter AW = 19
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // axi4-lite write address
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // flash pins
  output wire [AW-1:0] fl_addr,
  input wire [7:0] fl_dq_in,
  output wire [7:0] fl_dq_out,
  output wire fl_dq_oe,
  output wire fl_ce_n,
  output wire fl_oe_n,
  output wire fl_we_n
);

  localparam S_IDLE = 3'h0;
  localparam S_ISSUE = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_EVAL = 3'h3;
  localparam S_RST = 3'h4;
  localparam S_RWAIT = 3'h5;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg [AW-1:0] addr_reg;
  reg [7:0] data_reg;
  reg [1:0] op_reg;
  reg use_t2_reg;
  reg done_reg;
  reg fail_reg;
  reg ewc_reg;
  reg [7:0] rd_reg;
  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [7:0] first_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [4:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire cyc_done;
  wire [7:0] cyc_rdata;
  wire cyc_req;
  wire cyc_wr;
  wire [7:0] cyc_wdata;

  // --------------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------------
  // each channel is taken once and held until both are in; neither is taken again until the response is accepted
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire aw_now = s_axi_awvalid & s_axi_awready;
  wire w_now = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_reg | aw_now;
  wire w_have = w_held_reg | w_now;
  wire [4:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire & (wr_addr == `FLSH_REG_CTRL) & wr_strb[0];
  wire wr_stat = wr_fire & (wr_addr == `FLSH_REG_STAT) & wr_strb[0];
  wire start = wr_ctrl & wr_data[`FLSH_CTRL_START] & (state_reg == S_IDLE);
  wire abort = wr_ctrl & wr_data[`FLSH_CTRL_ABORT];
  wire wr_mapped = (wr_addr == `FLSH_REG_CTRL) | (wr_addr == `FLSH_REG_ADDR) |
    (wr_addr == `FLSH_REG_DATA) | (wr_addr == `FLSH_REG_STAT);

  always @(posedge clk) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      addr_reg <= {AW{1'b0}};
      data_reg <= 8'h00;
      op_reg <= `FLSH_OP_READ;
      use_t2_reg <= 1'b0;
    end else begin
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
      end else begin
        if (aw_now) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_now) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
      end
      // operand registers are frozen while an operation runs
      if (wr_fire & (state_reg == S_IDLE)) begin
        if (wr_addr == `FLSH_REG_ADDR) begin
          if (wr_strb[0]) addr_reg[7:0] <= wr_data[7:0];
          if (wr_strb[1]) addr_reg[15:8] <= wr_data[15:8];
          if (wr_strb[2]) addr_reg[AW-1:16] <= wr_data[AW-1:16];
        end
        if ((wr_addr == `FLSH_REG_DATA) & wr_strb[0]) begin
          data_reg <= wr_data[7:0];
        end
        if (wr_ctrl) begin
          op_reg <= wr_data[`FLSH_CTRL_OP_HI:`FLSH_CTRL_OP_LO];
          use_t2_reg <= wr_data[`FLSH_CTRL_USE_T2];
        end
      end
    end
  end

  // read channel
  wire [31:0] stat_word = {16'h0000, rd_reg, 4'h0, ewc_reg, fail_reg, done_reg,
    (state_reg != S_IDLE)};

  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `FLSH_REG_CTRL: s_axi_rdata <= {27'h0000000, 1'b0, use_t2_reg, op_reg, 1'b0};
        `FLSH_REG_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, addr_reg};
        `FLSH_REG_DATA: s_axi_rdata <= {24'h000000, data_reg};
        `FLSH_REG_STAT: s_axi_rdata <= stat_word;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // polling sequencer
  // --------------------------------------------------------------------
  wire [7:0] rd = cyc_rdata;
  wire poll_true = rd[`FLSH_POLARITY_POLL_BIT] == data_reg[`FLSH_POLARITY_POLL_BIT];
  wire t_changed = (rd[`FLSH_BUSY_TOGGLE_BIT] != first_reg[`FLSH_BUSY_TOGGLE_BIT]) |
    (use_t2_reg & (rd[`FLSH_SECTOR_ERASE_TOGGLE_BIT] !=
    first_reg[`FLSH_SECTOR_ERASE_TOGGLE_BIT]));
  wire tmo = rd[`FLSH_TIMEOUT_FAILURE_BIT];

  assign cyc_req = (state_reg == S_ISSUE) | (state_reg == S_RST);
  assign cyc_wr = (state_reg == S_RST) | (op_reg == `FLSH_OP_WRITE);
  assign cyc_wdata = (state_reg == S_RST) ? `FLSH_CMD_RESET : data_reg;

  // an abort write is remembered until the sequencer reaches a cycle boundary
  reg abort_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      phase_reg <= 2'h0;
      first_reg <= 8'h00;
      rd_reg <= 8'h00;
      ewc_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      // done and fail are sticky; a set later in this process wins over the clear
      done_reg <= done_reg & ~(wr_stat & wr_data[`FLSH_STAT_DONE]);
      fail_reg <= fail_reg & ~(wr_stat & wr_data[`FLSH_STAT_FAIL]);
      if (state_reg == S_IDLE) begin
        abort_reg <= 1'b0;
      end else if (abort) begin
        abort_reg <= 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          // a new command always starts from the first read
          if (start) begin
            phase_reg <= 2'h0;
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) state_reg <= S_EVAL;
        end
        S_EVAL: begin
          rd_reg <= rd;
          state_reg <= S_ISSUE;
          if (!cyc_wr) ewc_reg <= rd[`FLSH_ERASE_WINDOW_CLOSED_BIT];
          case (op_reg)
            `FLSH_OP_DPOLL: begin
              // reads at addr_reg, which software sets to the target
              case (phase_reg)
                2'h0: begin
                  if (poll_true) phase_reg <= 2'h1;
                  else if (tmo) phase_reg <= 2'h2;
                end
                2'h1: begin
                  // read after the flip carries the settled byte
                  done_reg <= 1'b1;
                  state_reg <= S_IDLE;
                end
                default: begin
                  if (poll_true) phase_reg <= 2'h1;
                  else state_reg <= S_RST;
                end
              endcase
            end
            `FLSH_OP_TOGGLE: begin
              case (phase_reg)
                2'h0: begin
                  first_reg <= rd;
                  phase_reg <= 2'h1;
                end
                2'h1: begin
                  if (!t_changed) begin
                    done_reg <= 1'b1;
                    state_reg <= S_IDLE;
                  end else if (tmo) begin
                    phase_reg <= 2'h2;
                  end else begin
                    phase_reg <= 2'h0;
                  end
                end
                2'h2: begin
                  first_reg <= rd;
                  phase_reg <= 2'h3;
                end
                default: begin
                  if (!t_changed) begin
                    done_reg <= 1'b1;
                    state_reg <= S_IDLE;
                  end else begin
                    state_reg <= S_RST;
                  end
                end
              endcase
            end
            default: begin
              // plain read returns array bytes when the flash is idle
              done_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          endcase
        end
        S_RST: begin
          state_reg <= S_RWAIT;
        end
        S_RWAIT: begin
          if (cyc_done) begin
            done_reg <= 1'b1;
            fail_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // a pending abort acts only at a cycle boundary so no strobe is cut short
      if (abort_reg & (state_reg == S_EVAL)) begin
        state_reg <= S_IDLE;
      end
    end
  end

  // --------------------------------------------------------------------
  // bus cycle engine
  // --------------------------------------------------------------------
  flsh_cyc #(
    .AW(AW)
  ) u_cyc (
    .clk(clk),
    .rst_n(rst_n),
    .req(cyc_req),
    .wr(cyc_wr),
    .addr(addr_reg),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

endmodule

// ==== tb/flsh_poll_properties.sv ====
/*
  Checker for the flash polling controller: flash strobe shapes, pin holds
  and the register-bus read answer.
  Assumes it is bound to the controller's top module and sees its ports.
*/
`timescale 1ns/1ps

module flsh_poll_properties #(
  parameter AW = 19
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register bus
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_rresp,
  // flash pins
  input wire [AW-1:0] fl_addr,
  input wire [7:0] fl_dq_out,
  input wire fl_dq_oe,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_read_three: assert property ($fell(fl_oe_n) |-> (!fl_oe_n) [*3] ##1 fl_oe_n)
    else $error("read strobe not three cycles");
  a_write_two: assert property ($fell(fl_we_n) |-> (!fl_we_n) [*2] ##1 fl_we_n)
    else $error("write strobe not two cycles");
  a_strobe_gap: assert property ($rose(fl_oe_n) || $rose(fl_we_n)
    |-> (fl_oe_n && fl_we_n) [*2])
    else $error("strobes too close");
  a_read_quiet: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n && !fl_ce_n)
    else $error("read cycle drives bus");
  a_write_drives: assert property (!fl_we_n |-> fl_dq_oe && fl_oe_n && !fl_ce_n)
    else $error("write cycle without data");
  a_addr_held: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
    else $error("address moved in cycle");
  a_wdata_held: assert property (!fl_we_n && !$past(fl_we_n) |-> $stable(fl_dq_out))
    else $error("write data moved in cycle");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  c_flash_read: cover property ($fell(fl_oe_n));
  c_flash_write: cover property ($fell(fl_we_n));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind flsh_poll flsh_poll_properties #(.AW(AW)) u_props (
  .clk(clk),
  .rst_n(rst_n),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rresp(s_axi_rresp),
  .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe),
  .fl_ce_n(fl_ce_n),
  .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n)
);

// ==== tb/flsh_flash_model.sv ====
/*
  Behavioural byte-wide flash: sixteen array bytes, program and erase with
  status on reads, reset command.
  Assumes busy time is counted in read cycles, not real time.
*/
`timescale 1ns/1ps

module flsh_flash_model (
  // flash pins
  input wire [18:0] fl_addr,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  input wire [7:0] fl_dq_wr,
  output wire [7:0] fl_dq_rd,
  // scenario controls
  input wire erase_go,
  input wire [3:0] busy_len
);
  reg [7:0] mem [0:15];
  reg [1:0] st_reg;
  reg [7:0] pd_reg;
  reg [7:0] last_reg;
  reg [3:0] pa_reg;
  reg [3:0] cnt_reg;
  reg tg_reg, tg2_reg, bad_reg, rd_arm, wr_arm, prot_reg;
  integer i;
  wire hit = fl_addr[3:0] == pa_reg;
  wire [7:0] cur = (st_reg == 2'h0) ? mem[fl_addr[3:0]] :
    (st_reg == 2'h2) ? {1'b0, tg_reg, 3'h1, tg2_reg, 2'h0} :
    {hit ? ~pd_reg[7] : pd_reg[7], tg_reg, st_reg == 2'h3, 5'h00};

  // a released bus shows the inverse of the last byte, never a kind value
  assign fl_dq_rd = (!fl_ce_n && !fl_oe_n) ? cur : ~last_reg;

  initial begin
    for (i = 0; i < 16; i = i + 1) mem[i] = 8'hC0 + i[7:0];
    {st_reg, pd_reg, last_reg, pa_reg, cnt_reg} = 26'h0;
    {tg_reg, tg2_reg, bad_reg, rd_arm, wr_arm, prot_reg} = 6'h00;
  end

  // arming on the falling strobe ignores the x-to-1 edge at power-up
  always @(negedge fl_oe_n) begin
    last_reg = cur;
    rd_arm = 1'b1;
  end
  always @(negedge fl_we_n) wr_arm = 1'b1;

  always @(posedge fl_oe_n) if (rd_arm) begin
    rd_arm = 1'b0;
    if (st_reg != 2'h0) tg_reg = ~tg_reg;
    if (st_reg == 2'h2) tg2_reg = ~tg2_reg;
    if (st_reg == 2'h1 || st_reg == 2'h2) begin
      if (cnt_reg != 4'h0) cnt_reg = cnt_reg - 4'h1;
      else if (bad_reg) st_reg = 2'h3;
      else begin
        // the upper half of the array is protected: neither programmed nor erased
        if (st_reg == 2'h1 && !prot_reg) mem[pa_reg] = pd_reg;
        else if (st_reg == 2'h2) for (i = 0; i < 8; i = i + 1) mem[i] = 8'hFF;
        st_reg = 2'h0;
      end
    end
  end

  always @(posedge fl_we_n) if (wr_arm) begin
    wr_arm = 1'b0;
    if (fl_dq_wr == 8'hF0) st_reg = 2'h0;
    else if (st_reg == 2'h0) begin
      pa_reg = fl_addr[3:0];
      pd_reg = fl_dq_wr;
      prot_reg = fl_addr[3];
      bad_reg = !fl_addr[3] && |(fl_dq_wr & ~mem[fl_addr[3:0]]);
      cnt_reg = busy_len;
      st_reg = 2'h1;
    end
  end

  always @(posedge erase_go) if (st_reg == 2'h0) begin
    st_reg = 2'h2;
    cnt_reg = busy_len;
    bad_reg = 1'b0;
  end
endmodule

// ==== tb/flsh_poll_bench.sv ====
/*
  Testbench of the flash polling controller: register-bus tasks and
  sequences of operations against the flash model.
  Assumes the controller's register map and timing from its header.
*/
`timescale 1ns/1ps
`include "flsh_consts.vh"

module flsh_poll_bench;
  reg clk, rst_n, awvalid, wvalid, bready, arvalid, rready, erase_go;
  reg [4:0] awaddr, araddr;
  reg [31:0] wdata, s, rd;
  reg [3:0] wstrb, busy_len;
  reg [1:0] rr, br;
  wire awready, wready, bvalid, arready, rvalid, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [18:0] fl_addr;
  wire [7:0] fl_dq_out, fl_dq_in, mq;
  integer miscompares, checks;

  assign fl_dq_in = fl_dq_oe ? fl_dq_out : mq;

  flsh_poll #(.AW(19)) u_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n)
  );

  flsh_flash_model u_flash (
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_dq_wr(fl_dq_out), .fl_dq_rd(mq), .erase_go(erase_go), .busy_len(busy_len)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task print_verdict;
    begin
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input [127:0] n, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", n, exp, seen);
      end
    end
  endtask

  // ready is sampled at the falling edge so the rising edge acts on it race-free
  task axi_wr(input [4:0] a, input [31:0] d);
    reg ta, tw, pa, pw;
    begin
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(negedge clk);
        pa = awready && !ta;
        pw = wready && !tw;
        @(posedge clk);
        if (pa) begin awvalid <= 1'b0; ta = 1'b1; end
        if (pw) begin wvalid <= 1'b0; tw = 1'b1; end
      end
      ta = 1'b0;
      while (!ta) begin @(negedge clk); ta = bvalid; br = bresp; @(posedge clk); end
    end
  endtask

  task axi_rd(input [4:0] a);
    reg t;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      t = 1'b0;
      while (!t) begin @(negedge clk); t = arready; @(posedge clk); end
      arvalid <= 1'b0;
      t = 1'b0;
      while (!t) begin @(negedge clk); t = rvalid; rd = rdata; rr = rresp; @(posedge clk); end
    end
  endtask

  task run(input [1:0] o, input [18:0] a, input [7:0] d, input t2);
    integer n;
    begin
      axi_wr(`FLSH_REG_STAT, 32'h6);
      axi_wr(`FLSH_REG_ADDR, {13'h0, a});
      axi_wr(`FLSH_REG_DATA, {24'h0, d});
      axi_wr(`FLSH_REG_CTRL, {28'h0, t2, o, 1'b1});
      n = 0;
      s = 32'h0;
      while (s[`FLSH_STAT_DONE] !== 1'b1 && n < 300) begin
        axi_rd(`FLSH_REG_STAT);
        s = rd;
        n = n + 1;
      end
      chk("run_done", {31'h0, s[`FLSH_STAT_DONE]}, 32'h1);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares = miscompares + 1;
    print_verdict;
  end

  initial begin
    {rst_n, awvalid, wvalid, arvalid, erase_go} = 5'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 42'h0;
    wstrb = 4'hF;
    busy_len = 4'h3;
    miscompares = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_rd(`FLSH_REG_STAT); chk("stat_reset", rd, 32'h0);
    axi_rd(`FLSH_REG_CTRL); chk("ctrl_reset", rd, 32'h0);
    axi_rd(5'h10); chk("unmapped_resp", {30'h0, rr}, 32'h2);
    chk("unmapped_data", rd, 32'h0);
    axi_wr(5'h14, 32'h0);
    chk("unmapped_wr", {30'h0, br}, 32'h2);
    run(`FLSH_OP_READ, 19'h3, 8'h00, 1'b0);
    chk("array", {24'h0, s[15:8]}, 32'hC3);
    run(`FLSH_OP_WRITE, 19'h5, 8'h40, 1'b0);
    run(`FLSH_OP_DPOLL, 19'h5, 8'h40, 1'b0);
    chk("poll_ok", {29'h0, s[2:0]}, 32'h2);
    chk("poll_byte", {24'h0, s[15:8]}, 32'h40);
    run(`FLSH_OP_WRITE, 19'h6, 8'h46, 1'b0);
    run(`FLSH_OP_TOGGLE, 19'h6, 8'h00, 1'b0);
    chk("tgl_ok", {29'h0, s[2:0]}, 32'h2);
    run(`FLSH_OP_READ, 19'h6, 8'h00, 1'b0);
    chk("prog_byte", {24'h0, s[15:8]}, 32'h46);
    run(`FLSH_OP_WRITE, 19'h5, 8'hFF, 1'b0);
    run(`FLSH_OP_DPOLL, 19'h5, 8'hFF, 1'b0);
    chk("poll_fail", {29'h0, s[2:0]}, 32'h6);
    run(`FLSH_OP_READ, 19'h5, 8'h00, 1'b0);
    chk("after_rst", {24'h0, s[15:8]}, 32'h40);
    axi_wr(`FLSH_REG_STAT, 32'h6);
    chk("wr_okay", {30'h0, br}, 32'h0);
    axi_rd(`FLSH_REG_STAT);
    chk("w1c", {30'h0, rd[2:1]}, 32'h0);
    run(`FLSH_OP_WRITE, 19'h7, 8'hFF, 1'b0);
    run(`FLSH_OP_TOGGLE, 19'h7, 8'h00, 1'b0);
    chk("tgl_fail", {29'h0, s[2:0]}, 32'h6);
    run(`FLSH_OP_READ, 19'h7, 8'h00, 1'b0);
    chk("kept", {24'h0, s[15:8]}, 32'hC7);
    // program into the protected half: busy for a while, array unchanged
    run(`FLSH_OP_WRITE, 19'hA, 8'h00, 1'b0);
    run(`FLSH_OP_TOGGLE, 19'hA, 8'h00, 1'b0);
    chk("prot_tgl", {29'h0, s[2:0]}, 32'h2);
    run(`FLSH_OP_READ, 19'hA, 8'h00, 1'b0);
    chk("prot_kept", {24'h0, s[15:8]}, 32'hCA);
    // a poll that can never see true data ends only through abort
    axi_wr(`FLSH_REG_STAT, 32'h6);
    axi_wr(`FLSH_REG_ADDR, 32'h3);
    axi_wr(`FLSH_REG_DATA, 32'h0);
    axi_wr(`FLSH_REG_CTRL, 32'h5);
    axi_wr(`FLSH_REG_CTRL, 32'h10);
    repeat (20) @(posedge clk);
    axi_rd(`FLSH_REG_STAT);
    chk("abort_idle", {29'h0, rd[2:0]}, 32'h0);
    erase_go <= 1'b1;
    @(posedge clk);
    erase_go <= 1'b0;
    run(`FLSH_OP_DPOLL, 19'h2, 8'h80, 1'b0);
    chk("erase_ok", {29'h0, s[2:0]}, 32'h2);
    chk("erase_byte", {24'h0, s[15:8]}, 32'hFF);
    chk("erase_ewc", {31'h0, s[3]}, 32'h1);
    run(`FLSH_OP_READ, 19'hA, 8'h00, 1'b0);
    chk("erase_prot", {24'h0, s[15:8]}, 32'hCA);
    erase_go <= 1'b1;
    @(posedge clk);
    erase_go <= 1'b0;
    run(`FLSH_OP_TOGGLE, 19'h9, 8'h00, 1'b1);
    chk("t2_ok", {29'h0, s[2:0]}, 32'h2);
    axi_rd(`FLSH_REG_CTRL); chk("ctrl_back", rd, 32'hE);
    print_verdict;
  end
endmodule
